// [src/gpl_port.sv]
// programmable nine-line io port with change-of-state interrupt and axi4-lite slave
// What this block does
// [RULE1] nine lines, each usable as input, output or change interrupt source
// [RULE2] function-select bit n set gives line n general purpose, clear gives alternate
// [RULE3] function select resets to all ones, lines 0-7 general purpose
// [RULE4] data-high bit 1 picks line 8 function; clear routes aux pwm zero
// [RULE5] direction registers: clear is input, set is output
// [RULE6] reset clears both direction registers, all lines inputs
// [RULE7] data registers read input levels and drive output levels
// [RULE8] line interrupts only when enabled, general purpose and input
// [RULE9] both rising and falling edges count as events
// [RULE10] an event sets its flag and raises the shared interrupt
// [RULE11] reading a flag register returns it then clears all its bits
// [RULE12] reset clears all interrupt enables
// [RULE13] lines 0-5 serial, 6 clock out, 7 aux pwm one, 8 aux pwm zero
// [RULE14] software keeps both frame syncs in serial function when serial used
// [RULE15] software clears select bit 3 with external serial clock
// [RULE16] mode bit 4 picks receive pin b (line 2) or pin a (line 4)
// [RULE17] line interrupt joins other peripheral interrupts on one core input
// [RULE18] software sets core mask bit 9 before interrupts reach the core
// [RULE19] interrupt line held low while flags pending, released after reads
// [RULE20] two-flop input sync, edge compare, set wins over read clear
`timescale 1ns/10ps
`default_nettype none
module gpl_port (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [8:0] lineIn,
    output gpl_pkg::gpl_pin_drive_t lineDrive,
    input wire gpl_pkg::gpl_alt_in_t altIn,
    input wire logic otherPeriphIrqN,
    output logic serialRxData,
    output logic peripheralCoreInterruptN
);
    logic [7:0] funcSel_r;
    logic [7:0] dirLow_r;
    logic dirHigh_r;
    logic [7:0] dataLow_r;
    logic [1:0] dataHigh_r;
    logic [7:0] irqEnLow_r;
    logic irqEnHigh_r;
    logic [7:0] flagsLow_r;
    logic flagsHigh_r;
    logic [7:0] mode_control_word_r;
    logic [8:0] sync1_r;
    logic [8:0] sync2_r;
    logic [8:0] prev_r;
    logic [8:0] isGp;
    logic [8:0] isOut;
    logic [8:0] irqEn;
    logic [8:0] lineEvent;
    logic [8:0] driveLevel;
    logic [8:0] driveEn;
    logic [8:0] gpData;
    logic [5:0] awAddr_r;
    logic awHave_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic wHave_r;
    logic doWrite;
    logic doRead;
    logic readFlagsLow;
    logic readFlagsHigh;
    logic [31:0] rdMux;
    logic rdOk;

    // per-line view of function, direction and enable
    always_comb begin
        isGp = {dataHigh_r[gpl_pkg::DATA_HIGH_SEL_BIT], funcSel_r}; // RULE2 RULE4
        isOut = {dirHigh_r, dirLow_r}; // RULE5
        irqEn = {irqEnHigh_r, irqEnLow_r};
        gpData = {dataHigh_r[gpl_pkg::DATA_HIGH_LEVEL_BIT], dataLow_r}; // RULE7
    end

    // input synchroniser; first stage feeds only the second
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync1_r <= 9'h000;
            sync2_r <= 9'h000;
            prev_r <= 9'h000;
        end else begin
            sync1_r <= lineIn; // RULE20
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    // change detect and pin muxing, one slice per line
    genvar g;
    generate
        for (g = 0; g < gpl_pkg::NUM_LINES; g++) begin : gLine
            // either edge qualifies; only enabled general-purpose inputs
            assign lineEvent[g] = (sync2_r[g] ^ prev_r[g]) // RULE9 RULE20
                & irqEn[g] & isGp[g] & ~isOut[g]; // RULE8 RULE1
            if (g < 6) begin : gSer
                assign driveLevel[g] = isGp[g] ? gpData[g] : altIn.serialOut[g]; // RULE13
                assign driveEn[g] = isGp[g] ? isOut[g] : altIn.serialOutEn[g];
            end else if (g == 6) begin : gClk
                assign driveLevel[g] = isGp[g] ? gpData[g] : altIn.clockOut; // RULE13
                assign driveEn[g] = isGp[g] ? isOut[g] : 1'b1;
            end else if (g == 7) begin : gAux1
                assign driveLevel[g] = isGp[g] ? gpData[g] : altIn.auxPwmOne; // RULE13
                assign driveEn[g] = isGp[g] ? isOut[g] : 1'b1;
            end else begin : gAux0
                assign driveLevel[g] = isGp[g] ? gpData[g] : altIn.auxPwmZero; // RULE4
                assign driveEn[g] = isGp[g] ? isOut[g] : 1'b1;
            end
        end
    endgenerate

    // pin drivers registered so outputs come from flops; costs one cycle of lag
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            lineDrive <= '0;
        end else begin
            lineDrive.dataOut <= driveLevel; // RULE7
            lineDrive.outEn <= driveEn; // RULE5
        end
    end

    // receive pin select: b is line 2, a is line 4
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            serialRxData <= 1'b0;
        end else if (mode_control_word_r[gpl_pkg::MODE_RX_SEL_BIT]) begin
            serialRxData <= sync2_r[2]; // RULE16
        end else begin
            serialRxData <= sync2_r[4]; // RULE16
        end
    end

    // write channel capture, address and data taken in either order
    assign doWrite = awHave_r & wHave_r & ~s_axi_bvalid;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            awHave_r <= 1'b0;
            wHave_r <= 1'b0;
            awAddr_r <= 6'h00;
            wData_r <= 32'h0000_0000;
            wStrb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= gpl_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= ~awHave_r & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~wHave_r & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHave_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHave_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHave_r <= 1'b0;
                wHave_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= writeOk(awAddr_r) ? gpl_pkg::RESP_OKAY : gpl_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // writable offsets; flag registers are read-only
    function automatic logic writeOk(input logic [5:0] a);
        case (a)
            gpl_pkg::OFS_FUNC_SEL, gpl_pkg::OFS_DIR_LOW, gpl_pkg::OFS_DIR_HIGH,
            gpl_pkg::OFS_DATA_LOW, gpl_pkg::OFS_DATA_HIGH, gpl_pkg::OFS_IRQ_EN_LOW,
            gpl_pkg::OFS_IRQ_EN_HIGH, gpl_pkg::OFS_MODE_CTRL: writeOk = 1'b1;
            default: writeOk = 1'b0;
        endcase
    endfunction

    // control registers, byte lane 0 only carries data
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            funcSel_r <= gpl_pkg::FUNC_SEL_RESET; // RULE3
            dirLow_r <= gpl_pkg::DIR_RESET; // RULE6
            dirHigh_r <= 1'b0; // RULE6
            dataLow_r <= 8'h00;
            dataHigh_r <= gpl_pkg::DATA_HIGH_RESET;
            irqEnLow_r <= gpl_pkg::IRQ_EN_RESET; // RULE12
            irqEnHigh_r <= 1'b0; // RULE12
            mode_control_word_r <= gpl_pkg::MODE_CTRL_RESET;
        end else if (doWrite && wStrb_r[0]) begin
            case (awAddr_r)
                gpl_pkg::OFS_FUNC_SEL: funcSel_r <= wData_r[7:0]; // RULE2
                gpl_pkg::OFS_DIR_LOW: dirLow_r <= wData_r[7:0]; // RULE5
                gpl_pkg::OFS_DIR_HIGH: dirHigh_r <= wData_r[0];
                gpl_pkg::OFS_DATA_LOW: dataLow_r <= wData_r[7:0]; // RULE7
                gpl_pkg::OFS_DATA_HIGH: dataHigh_r <= wData_r[1:0]; // RULE4
                gpl_pkg::OFS_IRQ_EN_LOW: irqEnLow_r <= wData_r[7:0]; // RULE8
                gpl_pkg::OFS_IRQ_EN_HIGH: irqEnHigh_r <= wData_r[0];
                gpl_pkg::OFS_MODE_CTRL: mode_control_word_r <= wData_r[7:0]; // RULE16
                default: ;
            endcase
        end
    end

    // read mux: input lines show pin level, output lines the latch
    always_comb begin
        rdMux = 32'h0000_0000;
        rdOk = 1'b1;
        case (s_axi_araddr)
            gpl_pkg::OFS_FUNC_SEL: rdMux[7:0] = funcSel_r;
            gpl_pkg::OFS_DIR_LOW: rdMux[7:0] = dirLow_r;
            gpl_pkg::OFS_DIR_HIGH: rdMux[0] = dirHigh_r;
            gpl_pkg::OFS_DATA_LOW: rdMux[7:0] = (dirLow_r & dataLow_r)
                | (~dirLow_r & sync2_r[7:0]); // RULE7
            gpl_pkg::OFS_DATA_HIGH: rdMux[1:0] = {dataHigh_r[1],
                dirHigh_r ? dataHigh_r[0] : sync2_r[8]}; // RULE7
            gpl_pkg::OFS_IRQ_EN_LOW: rdMux[7:0] = irqEnLow_r;
            gpl_pkg::OFS_IRQ_EN_HIGH: rdMux[0] = irqEnHigh_r;
            gpl_pkg::OFS_FLAGS_LOW: rdMux[7:0] = flagsLow_r; // RULE11
            gpl_pkg::OFS_FLAGS_HIGH: rdMux[0] = flagsHigh_r; // RULE11
            gpl_pkg::OFS_MODE_CTRL: rdMux[7:0] = mode_control_word_r;
            default: rdOk = 1'b0;
        endcase
    end

    // read channel: address taken when no answer is pending
    assign doRead = s_axi_arvalid & s_axi_arready;
    assign readFlagsLow = doRead & (s_axi_araddr == gpl_pkg::OFS_FLAGS_LOW);
    assign readFlagsHigh = doRead & (s_axi_araddr == gpl_pkg::OFS_FLAGS_HIGH);
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= gpl_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
            if (doRead) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdMux;
                s_axi_rresp <= rdOk ? gpl_pkg::RESP_OKAY : gpl_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // flags: clear on read, but a same-cycle event survives the clear
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            flagsLow_r <= 8'h00;
            flagsHigh_r <= 1'b0;
        end else begin
            flagsLow_r <= (readFlagsLow ? 8'h00 : flagsLow_r) // RULE11
                | lineEvent[7:0]; // RULE10 RULE20
            flagsHigh_r <= (readFlagsHigh ? 1'b0 : flagsHigh_r) // RULE11
                | lineEvent[8]; // RULE10 RULE20
        end
    end

    // active-low core interrupt: pending flags or any other peripheral source
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            peripheralCoreInterruptN <= 1'b1;
        end else begin
            peripheralCoreInterruptN <= ~((|flagsLow_r) | flagsHigh_r) & otherPeriphIrqN; // RULE17 RULE19
        end
    end

    // flag set and clear; the set wins so no edge is lost to a read
    a_flag_set_event: assert property (@(posedge clock) disable iff (!resetn) // RULE10
        lineEvent[0] |=> flagsLow_r[0])
        else $error("event did not set flag");

    a_read_clears_flags: assert property (@(posedge clock) disable iff (!resetn) // RULE11
        readFlagsLow && lineEvent[7:0] == 8'h00 |=> flagsLow_r == 8'h00)
        else $error("flag read did not clear");

    a_high_read_clears: assert property (@(posedge clock) disable iff (!resetn) // RULE11
        readFlagsHigh && !lineEvent[8] |=> !flagsHigh_r)
        else $error("high flag read did not clear");

    a_set_wins_clear: assert property (@(posedge clock) disable iff (!resetn) // RULE20
        readFlagsHigh && lineEvent[8] |=> flagsHigh_r)
        else $error("event lost during read");

    a_output_no_event: assert property (@(posedge clock) disable iff (!resetn) // RULE8
        isOut[3] |-> !lineEvent[3])
        else $error("output line raised event");

    // pin to flag takes three edges: two sync stages, then the compare
    sequence sPinRise0;
        !lineIn[0] ##1 lineIn[0];
    endsequence
    a_pin_to_flag: assert property (@(posedge clock) disable iff (!resetn) // RULE10 RULE20
        sPinRise0 |-> ##3 (flagsLow_r[0] || !$past(irqEn[0] && isGp[0] && !isOut[0])))
        else $error("pin edge not flagged in time");

    // both directions of a change count as an event
    sequence sEdge1;
        !sync2_r[1] ##1 sync2_r[1];
    endsequence
    sequence sFall8;
        sync2_r[8] ##1 !sync2_r[8];
    endsequence
    a_edge_detect: assert property (@(posedge clock) disable iff (!resetn) // RULE9
        sEdge1 ##0 (irqEn[1] && isGp[1] && !isOut[1]) |=> flagsLow_r[1])
        else $error("rising edge missed");

    a_fall_detect: assert property (@(posedge clock) disable iff (!resetn) // RULE9
        sFall8 ##0 (irqEn[8] && isGp[8] && !isOut[8]) |=> flagsHigh_r)
        else $error("falling edge missed");

    // interrupt line is a registered copy of the pending state
    a_irq_follows_flags: assert property (@(posedge clock) disable iff (!resetn) // RULE19
        flagsHigh_r |=> !peripheralCoreInterruptN)
        else $error("interrupt not asserted");

    a_irq_released: assert property (@(posedge clock) disable iff (!resetn) // RULE19
        (flagsLow_r == 8'h00 && !flagsHigh_r && otherPeriphIrqN) |=> peripheralCoreInterruptN)
        else $error("interrupt stuck low");

    a_irq_shared: assert property (@(posedge clock) disable iff (!resetn) // RULE17
        !otherPeriphIrqN |=> !peripheralCoreInterruptN)
        else $error("other peripheral interrupt not passed");

    // pin drive in general-purpose and alternate function
    a_line8_alt_drive: assert property (@(posedge clock) disable iff (!resetn) // RULE4
        !dataHigh_r[gpl_pkg::DATA_HIGH_SEL_BIT] |=> lineDrive.outEn[8])
        else $error("aux pwm zero not driven");

    a_gp_output_drive: assert property (@(posedge clock) disable iff (!resetn) // RULE7
        isGp[0] && isOut[0] |=> lineDrive.outEn[0]
            && lineDrive.dataOut[0] == $past(gpData[0]))
        else $error("output latch not driven");

    a_serial_alt_en: assert property (@(posedge clock) disable iff (!resetn) // RULE13
        !isGp[2] |=> lineDrive.outEn[2] == $past(altIn.serialOutEn[2])
            && lineDrive.dataOut[2] == $past(altIn.serialOut[2]))
        else $error("serial function not routed");

    a_clock_alt_drive: assert property (@(posedge clock) disable iff (!resetn) // RULE13
        !isGp[6] |=> lineDrive.outEn[6] && lineDrive.dataOut[6] == $past(altIn.clockOut))
        else $error("clock output not routed");

    a_gp_input_float: assert property (@(posedge clock) disable iff (!resetn) // RULE5 RULE1
        isGp[0] && !isOut[0] |=> !lineDrive.outEn[0])
        else $error("input line driven");

    // receive pin select follows mode bit 4
    a_rx_select: assert property (@(posedge clock) disable iff (!resetn) // RULE16
        mode_control_word_r[gpl_pkg::MODE_RX_SEL_BIT] && $stable(mode_control_word_r)
            |=> serialRxData == $past(sync2_r[2]))
        else $error("receive pin b not selected");

    a_rx_pin_a: assert property (@(posedge clock) disable iff (!resetn) // RULE16
        !mode_control_word_r[gpl_pkg::MODE_RX_SEL_BIT] |=> serialRxData == $past(sync2_r[4]))
        else $error("receive pin a not selected");
endmodule
`default_nettype wire

// [src/gpl_pkg.sv]
// package for the programmable io port: register map, resets, carriers
package gpl_pkg;
    // register byte offsets on the axi4-lite bus
    localparam logic [5:0] OFS_FUNC_SEL = 6'h00;
    localparam logic [5:0] OFS_DIR_LOW = 6'h04;
    localparam logic [5:0] OFS_DIR_HIGH = 6'h08;
    localparam logic [5:0] OFS_DATA_LOW = 6'h0C;
    localparam logic [5:0] OFS_DATA_HIGH = 6'h10;
    localparam logic [5:0] OFS_IRQ_EN_LOW = 6'h14;
    localparam logic [5:0] OFS_IRQ_EN_HIGH = 6'h18;
    localparam logic [5:0] OFS_FLAGS_LOW = 6'h1C;
    localparam logic [5:0] OFS_FLAGS_HIGH = 6'h20;
    localparam logic [5:0] OFS_MODE_CTRL = 6'h24;
    // field positions
    localparam int DATA_HIGH_LEVEL_BIT = 0;
    localparam int DATA_HIGH_SEL_BIT = 1;
    localparam int MODE_RX_SEL_BIT = 4;
    // reset values
    localparam logic [7:0] FUNC_SEL_RESET = 8'hFF;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] IRQ_EN_RESET = 8'h00;
    localparam logic [1:0] DATA_HIGH_RESET = 2'h2;
    localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
    localparam int NUM_LINES = 9;
    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // per-line pin carrier
    typedef struct packed {
        logic [8:0] dataOut;
        logic [8:0] outEn;
    } gpl_pin_drive_t;

    // alternate function carrier from the on-chip peripherals
    typedef struct packed {
        logic [5:0] serialOut;
        logic [5:0] serialOutEn;
        logic clockOut;
        logic auxPwmOne;
        logic auxPwmZero;
    } gpl_alt_in_t;
endpackage

// [verification/gpl_board.sv]
// board model on the nine port pins: pull-downs plus optional external drivers
`timescale 1ns/10ps
`default_nettype none
module gpl_board (
    input wire gpl_pkg::gpl_pin_drive_t lineDrive,
    input wire logic [8:0] extLevel,
    input wire logic [8:0] extEn,
    output logic [8:0] lineIn
);
    // port drive wins, then board driver; a released line reads low
    always_comb begin
        for (int i = 0; i < 9; i++) begin
            lineIn[i] = lineDrive.outEn[i] ? lineDrive.dataOut[i] : (extEn[i] & extLevel[i]);
        end
    end
endmodule
`default_nettype wire

// [verification/tb_programmable_io_port.sv]
// self-checking bench for the programmable io port
`timescale 1ns/10ps
`default_nettype none
module tb_programmable_io_port;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [5:0] awaddr = 6'h00;
    logic [5:0] araddr = 6'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, rxData, intN;
    logic [1:0] bresp, rresp, lastResp;
    logic [31:0] rdata, lastData;
    logic [8:0] lineIn;
    logic [8:0] extLevel = 9'h000;
    logic [8:0] extEn = 9'h000;
    logic otherIrqN = 1'b1;
    gpl_pkg::gpl_alt_in_t altIn = '0;
    logic [3:0] wstrb = 4'hF;
    logic [15:0] coreMask = 16'h0000; // core side mask word, bit 9 passes the line
    gpl_pkg::gpl_pin_drive_t lineDrive;
    int err_total = 0;
    int total_checks = 0;

    gpl_port dut (.clock(clock), .resetn(resetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .lineIn(lineIn), .lineDrive(lineDrive), .altIn(altIn),
        .otherPeriphIrqN(otherIrqN), .serialRxData(rxData),
        .peripheralCoreInterruptN(intN));
    gpl_board board (.lineDrive(lineDrive), .extLevel(extLevel), .extEn(extEn),
        .lineIn(lineIn));

    // 250 mhz clock
    initial begin
        forever #2 clock = ~clock;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    // write: both channels offered together, each dropped when taken; only the watchdog ends a hang
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        @(posedge clock);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        lastResp = bresp;
        bready <= 1'b0;
    endtask

    // read: rready held until rvalid is sampled
    task automatic rd(input logic [5:0] a);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        lastData = rdata;
        lastResp = rresp;
        rready <= 1'b0;
    endtask

    task automatic t_reset;
        logic [5:0] a [8];
        logic [31:0] e [8];
        a = '{6'h00, 6'h04, 6'h08, 6'h10, 6'h14, 6'h18, 6'h20, 6'h24};
        e = '{32'hFF, 32'h0, 32'h0, 32'h2, 32'h0, 32'h0, 32'h0, 32'h0};
        check("outEn", lineDrive.outEn, 9'h000);
        check("irq", intN, 1'b1);
        for (int i = 0; i < 8; i++) begin
            rd(a[i]);
            check("reset value", lastData, e[i]);
        end
        rd(6'h3C);
        check("unmapped rresp", lastResp, gpl_pkg::RESP_SLVERR);
        wr(gpl_pkg::OFS_FLAGS_LOW, 32'hFF);
        check("flag write bresp", lastResp, gpl_pkg::RESP_SLVERR);
        // lane 0 strobe low: answered but nothing stored
        wstrb <= 4'h0;
        wr(gpl_pkg::OFS_MODE_CTRL, 32'h10);
        check("masked write bresp", lastResp, gpl_pkg::RESP_OKAY);
        wstrb <= 4'hF;
        rd(gpl_pkg::OFS_MODE_CTRL);
        check("masked write", lastData, 32'h0);
    endtask

    task automatic t_output;
        extEn <= 9'h0F0;
        extLevel <= 9'h0A0;
        wr(gpl_pkg::OFS_DIR_LOW, 32'h0F);
        wr(gpl_pkg::OFS_DATA_LOW, 32'h05);
        wr(gpl_pkg::OFS_DIR_HIGH, 32'h1);
        wr(gpl_pkg::OFS_DATA_HIGH, 32'h3);
        cyc(3);
        check("outEn", lineDrive.outEn, 9'h10F);
        check("dataOut", lineDrive.dataOut & 9'h10F, 9'h105);
        rd(gpl_pkg::OFS_DATA_LOW);
        check("data low", lastData, 32'hA5);
        wr(gpl_pkg::OFS_DIR_LOW, 32'h0);
        wr(gpl_pkg::OFS_DIR_HIGH, 32'h0);
        wr(gpl_pkg::OFS_DATA_HIGH, 32'h2);
        extEn <= 9'h000;
    endtask

    task automatic t_alt;
        altIn <= {6'h3F, 6'h21, 1'b1, 1'b0, 1'b1};
        wr(gpl_pkg::OFS_FUNC_SEL, 32'hD8);
        cyc(3);
        check("outEn serial", lineDrive.outEn, 9'h021);
        wr(gpl_pkg::OFS_FUNC_SEL, 32'h00);
        wr(gpl_pkg::OFS_DATA_HIGH, 32'h0);
        cyc(3);
        check("outEn alt", lineDrive.outEn, 9'h1E1);
        check("dataOut alt", lineDrive.dataOut & 9'h1E1, 9'h161);
        wr(gpl_pkg::OFS_FUNC_SEL, 32'hFF);
        wr(gpl_pkg::OFS_DATA_HIGH, 32'h2);
    endtask

    task automatic t_irq;
        coreMask <= 16'h0200;
        wr(gpl_pkg::OFS_IRQ_EN_LOW, 32'h03);
        wr(gpl_pkg::OFS_IRQ_EN_HIGH, 32'h1);
        wr(gpl_pkg::OFS_DIR_LOW, 32'h02);
        wr(gpl_pkg::OFS_DATA_LOW, 32'h02);
        extEn <= 9'h105;
        extLevel <= 9'h005;
        cyc(6);
        check("irq low", intN, 1'b0);
        check("core irq", ~intN & coreMask[9], 1'b1);
        rd(gpl_pkg::OFS_FLAGS_LOW);
        check("flags low", lastData, 32'h01);
        rd(gpl_pkg::OFS_FLAGS_LOW);
        check("flags cleared", lastData, 32'h0);
        cyc(2);
        check("irq released", intN, 1'b1);
        extLevel <= 9'h100;
        cyc(6);
        rd(gpl_pkg::OFS_FLAGS_HIGH);
        check("flags high", lastData, 32'h1);
        rd(gpl_pkg::OFS_FLAGS_LOW);
        check("fall flag", lastData, 32'h01);
        cyc(2);
        check("irq idle", intN, 1'b1);
        otherIrqN <= 1'b0;
        cyc(3);
        check("shared irq", intN, 1'b0);
        otherIrqN <= 1'b1;
        wr(gpl_pkg::OFS_IRQ_EN_LOW, 32'h0);
        wr(gpl_pkg::OFS_DIR_LOW, 32'h0);
    endtask

    task automatic t_rx;
        extEn <= 9'h014;
        extLevel <= 9'h004;
        wr(gpl_pkg::OFS_MODE_CTRL, 32'h10);
        cyc(4);
        check("rx pin b", rxData, 1'b1);
        wr(gpl_pkg::OFS_MODE_CTRL, 32'h00);
        cyc(4);
        check("rx pin a", rxData, 1'b0);
        // line 8 was released to its pull-down at the start: a falling event
        rd(gpl_pkg::OFS_FLAGS_HIGH);
        check("line8 fall flag", lastData, 32'h1);
        // second reset in mid-run with an enable still set
        resetn <= 1'b0;
        cyc(2);
        check("irq in reset", intN, 1'b1);
        resetn <= 1'b1;
        cyc(1);
        rd(gpl_pkg::OFS_IRQ_EN_HIGH);
        check("enable after reset", lastData, 32'h0);
        rd(gpl_pkg::OFS_FUNC_SEL);
        check("select after reset", lastData, 32'hFF);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // main sequence after a two-cycle reset
    initial begin
        cyc(2);
        resetn <= 1'b1;
        cyc(1);
        t_reset();
        t_output();
        t_alt();
        t_irq();
        t_rx();
        tally_and_finish();
    end

    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        err_total++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
